// ===== hw/valley_switch_counter_logic.sv
// Switch-on control for a quasi-resonant flyback: soft-start sequencer,
// valley up/down counter, crossing counter, and gate flip-flop.
// Assumes comparator inputs are synchronous to sys_clk_in and glitch free.
//
// Overview of operation
// RL1: Supply-on indication stops startup source, starts soft-start
// RL2: Soft-start 12 ms, four limit steps
// RL3: Switch-on digital, switch-off from analog comparison
// RL4: Evaluate feedback thresholds every 48 ms
// RL5: Always below low limit: increment, cap 7
// RL6: Above low, never above high: hold
// RL7: Above high, never reset limit: decrement, floor 1
// RL8: Above reset limit: force counter to 1
// RL9: Counter confined to 1 through 7
// RL10: Counter starts at 1
// RL11: Counter value selects switch-on valley
// RL12: Low/high limits chosen by line level
// RL13: Crossing counter saturates 0 to 7
// RL14: Each falling crossing after switch-off counts one
// RL15: Crossing counter cleared on gate rising
// RL16: Overvoltage while off latches off after blanking
// RL17: After suppression, on when crossings reach counter
// RL18: No turn-on during suppression; long when low
// RL19: Maximum off time forces turn-on
// RL20: Current-sense over feedback resets gate
// RL21: Sticky threshold flags, priority reset-down-hold-up
// RL22: Soft-start steps equally spaced in time
`timescale 1ns/100ps
`default_nettype none

module valley_switch_counter_logic #(
  parameter longint unsigned SS_STEP = valley_pkg::SS_STEP_CYCLES,
  parameter longint unsigned EVAL_LEN = valley_pkg::EVAL_CYCLES,
  parameter int unsigned RING_SHORT = valley_pkg::RING_SHORT_CYCLES,
  parameter int unsigned RING_LONG = valley_pkg::RING_LONG_CYCLES,
  parameter int unsigned OFF_MAX = valley_pkg::OFF_MAX_CYCLES,
  parameter int unsigned OVP_BLANK = valley_pkg::OVP_BLANK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic supply_on_in,
  input wire logic high_line_in,
  input wire valley_pkg::comp_t comp_in,
  output logic gate_drive_output_out,
  output logic startup_source_on_out,
  output logic latched_off_out,
  output logic [1:0] cs_limit_code_out,
  output logic soft_start_active_out,
  output logic [2:0] valley_count_out,
  output logic [2:0] crossing_count_out,
  output logic high_line_limits_out
);

  typedef enum logic [1:0] {WAIT_SUPPLY, SOFT_START, RUN, LATCHED} mode_t;

  mode_t mode_q, mode_d;
  logic [31:0] ss_cnt_q;
  logic [1:0] cs_code_q;
  logic [31:0] eval_cnt_q;
  logic seen_up_q, seen_down_q, seen_reset_q;
  logic [2:0] ud_q, ud_d;
  logic [2:0] zc_q;
  logic gate_q;
  logic [15:0] off_cnt_q;
  logic [15:0] ovp_cnt_q;
  logic zc_above_q;
  logic thr_sel_q;
  logic ring_long_q;

  wire running = (mode_q == SOFT_START) || (mode_q == RUN);
  wire ss_step_done = (ss_cnt_q == 32'(SS_STEP - 1));
  wire eval_done = (eval_cnt_q == 32'(EVAL_LEN - 1));
  wire falling_cross = zc_above_q && !comp_in.zc_above_crossing && !gate_q;
  wire [15:0] ring_len = ring_long_q ? 16'(RING_LONG) : 16'(RING_SHORT);
  wire ring_over = (off_cnt_q >= ring_len);
  wire valley_hit = (zc_q >= ud_q);
  wire off_timeout = (off_cnt_q >= 16'(OFF_MAX - 1));
  wire gate_on_req = running && !gate_q && ((ring_over && valley_hit) || off_timeout);
  wire gate_off_req = gate_q && comp_in.cs_above_fb;
  wire ovp_trip = (ovp_cnt_q >= 16'(OVP_BLANK - 1)) && comp_in.zc_above_ovp && !gate_q;

  // Mode sequencing: supply-on to soft-start, final step to run
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      // RL1 supply-on starts soft-start
      WAIT_SUPPLY: if (supply_on_in) mode_d = SOFT_START;
      SOFT_START: if (ss_step_done && cs_code_q == valley_pkg::CS_LIMIT_FINAL) mode_d = RUN;
      RUN: mode_d = RUN;
      LATCHED: mode_d = LATCHED;
    endcase
    // RL16 overvoltage latch wins
    if (running && ovp_trip)
      mode_d = LATCHED;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      mode_q <= WAIT_SUPPLY;
    else
      mode_q <= mode_d;
  end

  // RL22 equal step spacing, RL2 four limit steps
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || mode_q != SOFT_START)
      ss_cnt_q <= 32'h0;
    else if (ss_step_done)
      ss_cnt_q <= 32'h0;
    else
      ss_cnt_q <= ss_cnt_q + 32'h1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || mode_q == WAIT_SUPPLY)
      cs_code_q <= valley_pkg::CS_LIMIT_FIRST;
    else if (mode_q == SOFT_START && ss_step_done && cs_code_q != valley_pkg::CS_LIMIT_FINAL)
      cs_code_q <= cs_code_q + 2'h1;
  end

  // RL4 evaluation period timer
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !running || eval_done)
      eval_cnt_q <= 32'h0;
    else
      eval_cnt_q <= eval_cnt_q + 32'h1;
  end

  // RL21 sticky threshold flags, restarted each period
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !running || eval_done)
    begin
      seen_up_q <= 1'b0;
      seen_down_q <= 1'b0;
      seen_reset_q <= 1'b0;
    end
    else
    begin
      seen_up_q <= seen_up_q | comp_in.fb_above_up_limit;
      seen_down_q <= seen_down_q | comp_in.fb_above_down_limit;
      seen_reset_q <= seen_reset_q | comp_in.fb_above_reset_limit;
    end
  end

  // Include this cycle's sample so the last cycle of a period counts
  wire any_up = seen_up_q | comp_in.fb_above_up_limit;
  wire any_down = seen_down_q | comp_in.fb_above_down_limit;
  wire any_reset = seen_reset_q | comp_in.fb_above_reset_limit;

  // RL21 priority reset over decrement over hold over increment
  always_comb
  begin
    ud_d = ud_q;
    if (any_reset)
      // RL8 force to one
      ud_d = valley_pkg::UD_MIN;
    else if (any_down)
    begin
      // RL7 decrement, RL9 floor
      if (ud_q > valley_pkg::UD_MIN)
        ud_d = ud_q - 3'h1;
    end
    else if (any_up)
      // RL6 hold
      ud_d = ud_q;
    else if (ud_q < valley_pkg::UD_MAX)
      // RL5 increment, RL9 ceiling
      ud_d = ud_q + 3'h1;
  end

  // RL10 start at one; RL4 update once per period
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || mode_q == WAIT_SUPPLY)
      ud_q <= valley_pkg::UD_RESET;
    else if (running && eval_done)
      ud_q <= ud_d;
  end

  // RL12 limit set follows line level, latched at period start
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      thr_sel_q <= 1'b0;
    else if (!running || eval_done)
      thr_sel_q <= high_line_in;
  end

  // Previous crossing comparator level for falling edge
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      zc_above_q <= 1'b0;
    else
      zc_above_q <= comp_in.zc_above_crossing;
  end

  // RL15 clear on gate rising; RL14 count crossings; RL13 saturate
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || gate_on_req)
      zc_q <= valley_pkg::ZC_RESET;
    else if (falling_cross && zc_q != valley_pkg::ZC_MAX)
      zc_q <= zc_q + 3'h1;
  end

  // RL18 suppression length picked at turn-off from sense level
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      ring_long_q <= 1'b0;
    else if (gate_off_req)
      ring_long_q <= !comp_in.zc_above_ring;
  end

  // Off-time counter drives suppression and maximum off time
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || gate_q || !running)
      off_cnt_q <= 16'h0;
    else if (off_cnt_q != 16'hFFFF)
      off_cnt_q <= off_cnt_q + 16'h1;
  end

  // RL16 overvoltage must persist through the blanking time
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || gate_q || !comp_in.zc_above_ovp)
      ovp_cnt_q <= 16'h0;
    else if (ovp_cnt_q != 16'hFFFF)
      ovp_cnt_q <= ovp_cnt_q + 16'h1;
  end

  // RL3 gate flip-flop: on from counters, off from analog path
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !running || ovp_trip)
      gate_q <= 1'b0;
    // RL20 current sense resets gate
    else if (gate_off_req)
      gate_q <= 1'b0;
    // RL17 valley reached, RL19 off-time limit, RL11 valley index
    else if (gate_on_req)
      gate_q <= 1'b1;
  end

  // Outputs
  assign gate_drive_output_out = gate_q;
  // RL1 startup source off once operating
  assign startup_source_on_out = (mode_q == WAIT_SUPPLY);
  assign latched_off_out = (mode_q == LATCHED);
  assign cs_limit_code_out = cs_code_q;
  assign soft_start_active_out = (mode_q == SOFT_START);
  assign valley_count_out = ud_q;
  assign crossing_count_out = zc_q;
  assign high_line_limits_out = thr_sel_q;

  // RL9 counter range
  a_ud_range: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ud_q >= 3'h1 && ud_q <= 3'h7) else $error("valley counter out of range");
  // RL8 reset limit forces one
  a_ud_force_one: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    running && eval_done && any_reset |=> ud_q == 3'h1) else $error("reset limit did not force one");
  // RL5 increment
  a_ud_increment: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    running && eval_done && !any_up && !any_down && !any_reset && ud_q < 3'h7 |=> ud_q == $past(ud_q) + 3'h1)
    else $error("counter did not increment");
  // RL6 hold
  a_ud_hold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    running && eval_done && any_up && !any_down && !any_reset |=> $stable(ud_q))
    else $error("counter did not hold");
  // RL15 cleared at gate rise
  a_zc_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(gate_q) |-> zc_q == 3'h0) else $error("crossing count not cleared");
  // RL20 current sense turns gate off
  a_gate_off: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    gate_q && comp_in.cs_above_fb |=> !gate_q) else $error("gate stayed on");
  // RL18 no turn-on inside short suppression
  a_ring_block: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(gate_q) |-> $past(off_cnt_q) >= 16'(RING_SHORT) || $past(off_timeout))
    else $error("gate rose during suppression");
  // RL1 startup source off after supply-on
  a_startup_off: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    mode_q == WAIT_SUPPLY && supply_on_in |=> !startup_source_on_out && soft_start_active_out)
    else $error("startup source not released");

endmodule : valley_switch_counter_logic

`default_nettype wire

// ===== common/valley_pkg.sv
// Package for the valley switch counter logic: timing counts, field widths,
// reset values and the packed structs that carry comparator and gate signals.
// Assumes a 250 MHz system clock; times are converted to cycles here.
package valley_pkg;

  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned SOFT_START_DURATION_US = 12000;
  localparam int unsigned EVAL_PERIOD_US = 48000;
  localparam int unsigned SOFT_START_STEPS = 4;
  localparam longint unsigned SOFT_START_CYCLES = longint'(SOFT_START_DURATION_US) * CLK_HZ / 1000000;
  localparam longint unsigned SS_STEP_CYCLES = SOFT_START_CYCLES / SOFT_START_STEPS;
  localparam longint unsigned EVAL_CYCLES = longint'(EVAL_PERIOD_US) * CLK_HZ / 1000000;

  // Suppression, off-time and blanking defaults, in cycles
  localparam int unsigned RING_SHORT_CYCLES = 250;
  localparam int unsigned RING_LONG_CYCLES = 1000;
  localparam int unsigned OFF_MAX_CYCLES = 12500;
  localparam int unsigned OVP_BLANK_CYCLES = 250;

  localparam int unsigned UD_WIDTH = 3;
  localparam logic [2:0] UD_MIN = 3'h1;
  localparam logic [2:0] UD_MAX = 3'h7;
  localparam logic [2:0] UD_RESET = 3'h1;
  localparam logic [2:0] ZC_MAX = 3'h7;
  localparam logic [2:0] ZC_RESET = 3'h0;

  // Current-sense limit codes: 0 = 0.32 V first step, 3 = 1 V final
  localparam logic [1:0] CS_LIMIT_FIRST = 2'h0;
  localparam logic [1:0] CS_LIMIT_FINAL = 2'h3;

  // Comparator results from the analog side, sampled each clock
  typedef struct packed {
    logic fb_above_up_limit;     // feedback_pin above feedback_count_up_limit
    logic fb_above_down_limit;   // above feedback_count_down_limit
    logic fb_above_reset_limit;  // above feedback_counter_reset_limit
    logic zc_above_crossing;     // valley_sense_pin above crossing_detect_threshold
    logic zc_above_ring;         // valley_sense_pin above ringing threshold
    logic zc_above_ovp;          // above output_overvoltage_threshold
    logic cs_above_fb;           // scaled current sense exceeds feedback
  } comp_t;

  typedef struct packed {
    logic gate;
    logic startup_source_on;
    logic latched_off;
    logic [1:0] cs_limit_code;
    logic soft_start_active;
  } drive_t;

endpackage : valley_pkg

// ===== verification/comparator_partner.sv
// Behavioural model of the analog comparators facing the switch-on logic.
// Assumes the bench sets feedback and sense levels at falling edges.
`timescale 1ns/100ps
`default_nettype none

module comparator_partner #(
  parameter int ON_LEN = 5
) (
  input wire logic clk_in,
  input wire logic gate_in,
  input wire logic [2:0] fb_lvl_in,
  input wire logic ring_lvl_in,
  input wire logic ovp_in,
  input wire logic [3:0] n_ring_in,
  output var valley_pkg::comp_t comp_out
);
  int on_q = 0;
  int ph_q = 0;

  // Current ramps while on; ringing phase runs while off
  always @(negedge clk_in)
  begin
    on_q <= gate_in ? on_q + 1 : 0;
    ph_q <= gate_in ? 0 : ph_q + 1;
  end

  // Ring is two cycles high, two low; pin is clamped low while on
  assign comp_out = {fb_lvl_in, (ph_q >= 1) && (ph_q <= 4 * n_ring_in) && ((ph_q - 1) % 4 < 2),
    ring_lvl_in, ovp_in && !gate_in, gate_in && (on_q >= ON_LEN)};
endmodule : comparator_partner
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the valley switch counter logic.
// Assumes shortened counts on the design so the run stays brief.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic sys_clk, srst, supply_on, high_line, ring_lvl, ovp;
  logic [2:0] fb_lvl;
  logic [3:0] n_ring;
  valley_pkg::comp_t comp;
  logic gate, startup_on, latched, ss_active, hl_limits;
  logic [1:0] cs_code;
  logic [2:0] valley, crossing, zc_pre, zc_post;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int off_n, on_n;

  // Long suppression keeps its default, so it outlasts the shortened off-time limit
  valley_switch_counter_logic #(.SS_STEP(20), .EVAL_LEN(50), .RING_SHORT(3), .OFF_MAX(40),
    .OVP_BLANK(4)) u_dut (.sys_clk_in(sys_clk), .srst_in(srst), .supply_on_in(supply_on),
    .high_line_in(high_line), .comp_in(comp), .gate_drive_output_out(gate), .startup_source_on_out(startup_on),
    .latched_off_out(latched), .cs_limit_code_out(cs_code), .soft_start_active_out(ss_active),
    .valley_count_out(valley), .crossing_count_out(crossing), .high_line_limits_out(hl_limits));

  comparator_partner u_far (.clk_in(sys_clk), .gate_in(gate), .fb_lvl_in(fb_lvl),
    .ring_lvl_in(ring_lvl), .ovp_in(ovp), .n_ring_in(n_ring), .comp_out(comp));

  // Clock, 4 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Hang guard: roughly twice the expected run
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // One full switching cycle: on time, off time, crossings around turn-on
  task automatic gate_cycle();
    // Skip a pulse already under way so the on time is measured whole
    for (int i = 0; i < 100 && gate !== 1'b0; i++) cyc(1);
    for (int i = 0; i < 100 && gate !== 1'b1; i++) cyc(1);
    on_n = 0;
    while (gate === 1'b1 && on_n < 100)
    begin
      cyc(1);
      on_n++;
    end
    off_n = 0;
    while (gate === 1'b0 && off_n < 100)
    begin
      zc_pre = crossing;
      cyc(1);
      off_n++;
    end
    zc_post = crossing;
  endtask : gate_cycle

  task automatic t_start();
    check("startup_src", startup_on, 1); // waiting
    check("valley_init", valley, 1); // start
    check("gate_idle", gate, 0); // idle
    check("cs_init", cs_code, 0); // first step
    supply_on = 1'b1;
    cyc(2);
    check("startup_off", startup_on, 0); // source off
    check("ss_on", ss_active, 1); // soft-start
    cyc(8);
    for (int k = 0; k < 4; k++)
    begin
      check("cs_step", cs_code, k[1:0]); // equal steps
      cyc(20);
    end
    check("ss_done", ss_active, 0); // four steps
  endtask : t_start

  task automatic t_gate();
    gate_cycle();
    check("on_len", on_n inside {[5:8]}, 1); // cs trip
    check("zc_at_on", zc_post, 0); // clear on rise
    check("zc_reach", zc_pre >= valley, 1); // count reached
    check("short_ring", off_n < 6, 1); // short
    ring_lvl = 1'b0;
    gate_cycle();
    // Long suppression runs past the off-time limit, so the forced turn-on ends it
    check("long_ring", off_n inside {[39:41]}, 1); // long
    n_ring = 4'h0;
    gate_cycle();
    check("max_off", off_n inside {[39:41]}, 1); // forced on
  endtask : t_gate

  task automatic t_eval();
    n_ring = 4'h8;
    ring_lvl = 1'b1;
    fb_lvl = 3'h0;
    cyc(420);
    check("valley_top", valley, 7); // climb, cap
    gate_cycle();
    check("zc_valley7", zc_pre, 7); // valley index
    fb_lvl = 3'h4;
    cyc(150);
    check("valley_hold", valley, 7); // hold
    fb_lvl = 3'h6;
    for (int i = 0; i < 60 && valley === 3'h7; i++) cyc(1);
    cyc(25);
    check("valley_dn1", valley, 6); // down by one
    cyc(50);
    check("valley_dn2", valley, 5); // once a period
    cyc(300);
    check("valley_floor", valley, 1); // floor
    fb_lvl = 3'h0;
    for (int i = 0; i < 60 && valley === 3'h1; i++) cyc(1);
    cyc(75);
    check("valley_up", valley, 3); // up one per period
    fb_lvl = 3'h7;
    cyc(5);
    fb_lvl = 3'h0;
    cyc(45);
    check("valley_rst", valley, 1); // forced to one
    high_line = 1'b1;
    cyc(110);
    check("hl_set", hl_limits, 1); // line select
    high_line = 1'b0;
    cyc(110);
    check("hl_clr", hl_limits, 0); // line select
  endtask : t_eval

  task automatic t_ovp();
    int highs;
    n_ring = 4'h0;
    check("not_latched", latched, 0); // no trip
    ovp = 1'b1;
    cyc(2);
    ovp = 1'b0;
    cyc(1);
    check("ovp_blanked", latched, 0); // blanking
    ovp = 1'b1;
    cyc(60);
    check("latched", latched, 1); // latch off
    ovp = 1'b0;
    highs = 0;
    repeat (100)
    begin
      cyc(1);
      highs += gate;
    end
    check("gate_held", highs, 0); // stays off
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    check("unlatched", latched, 0); // reset clears
    check("valley_rst2", valley, 1); // start
  endtask : t_ovp

  // Main sequence
  initial
  begin
    srst = 1'b1;
    supply_on = 1'b0;
    high_line = 1'b0;
    ring_lvl = 1'b1;
    ovp = 1'b0;
    fb_lvl = 3'h4;
    n_ring = 4'h3;
    cyc(8);
    srst = 1'b0;
    cyc(20);
    t_start();
    t_gate();
    t_eval();
    t_ovp();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
